// File: rfs_pkg.sv
// Package for the remap fault status block: offsets, fields, reset values.
package rfs_pkg;
    localparam int          SLOT_COUNT      = 8;
    localparam int          IDX_W           = 8;
    localparam logic [11:0] FSTS_OFFSET     = 12'h034;
    localparam logic [11:0] FECTL_OFFSET    = 12'h038;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h03c;
    localparam logic [11:0] IRQ_STAT_OFFSET = 12'h040;
    localparam logic [11:0] SLOT_OFFSET     = 12'h044;
    localparam int          OVR_BIT         = 0;
    localparam int          PEND_BIT        = 1;
    localparam int          IDX_LSB         = 8;
    localparam int          IDX_MSB         = 15;
    localparam int          MSG_MASK_BIT    = 31;
    localparam int          IP_BIT          = 30;
    localparam int          EV_PEND         = 0;
    localparam int          EV_OVR          = 1;
    localparam logic [31:0] FSTS_RESET      = 32'h0000_0000;
    localparam logic [31:0] FECTL_RESET     = 32'h8000_0000;
    localparam logic [1:0]  IRQ_MASK_RESET  = 2'h0;
    localparam logic [1:0]  IRQ_STAT_RESET  = 2'h0;
    localparam logic [7:0]  SLOT_RESET      = 8'h00;
endpackage

// File: rfs_fault_status.sv
// Fault status register bank of an address-remapping unit, with APB access.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
module rfs_fault_status
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fault_record,
    input  wire logic [7:0]  fault_slot,
    output logic             fault_msg,
    output logic             irq
);
    // Register map, one aligned 32-bit word each:
    //   034h  status: index in 15:8, pending summary in 1, overrun in 0 (write one to clear).
    //   038h  event control: message mask in 31 (set after reset), message pending in 30.
    //   03ch  interrupt enable, one bit per event: 0 is the pending rise, 1 the overrun.
    //   040h  interrupt status, same layout as the enable word, sticky, write one to clear.
    //   044h  slot markers, one bit per recording slot, write one to clear a slot.
    // Any other word answers with pslverr set, read data zero and no side effect.
    //
    // Hazards worth knowing before changing this block:
    //   The read word is taken in the setup cycle, so a fault that lands in the access
    //   cycle shows only on the next read of the status word.
    //   Every hardware set wins over a software clear in the same cycle, so an event
    //   can never be lost to a badly timed write.
    //   The slot markers stand in for the recording slots that live outside this block;
    //   they exist here so the pending summary and the overrun can be worked out.

    // Slot markers, status fields and event control state.
    logic [rfs_pkg::SLOT_COUNT-1:0] slot_valid_q;
    logic [rfs_pkg::IDX_W-1:0]      index_q;
    logic                           pend_q;
    logic                           ovr_q;
    logic                           msg_mask_q;
    logic                           ip_q;
    logic [1:0]                     irq_stat_q;
    logic [1:0]                     irq_mask_q;
    logic                           pend_d;
    logic                           pend_rise;
    logic                           wr_acc;
    logic                           slots_full;
    logic [rfs_pkg::SLOT_COUNT-1:0] slot_set;
    logic [rfs_pkg::SLOT_COUNT-1:0] slot_clr;
    logic [rfs_pkg::IDX_W-1:0]      first_idx;
    logic                           ovr_set;
    logic                           msg_send;

    // Register selects, write strobes and the read word in front of its flop.
    logic                           sel_fsts;
    logic                           sel_fectl;
    logic                           sel_imask;
    logic                           sel_istat;
    logic                           sel_slot;
    logic                           fsts_w1c;
    logic                           fectl_wr;
    logic                           imask_wr;
    logic                           istat_w1c;
    logic [31:0]                    rdata_d;
    logic                           rderr_d;

    // Matches the address against one register word.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    // Builds the status word; every bit outside the three fields stays zero.
    // Keeping the layout in one place stops the field positions drifting apart.
    function automatic logic [31:0] fsts_word(input logic [rfs_pkg::IDX_W-1:0] idx,
                                              input logic pend,
                                              input logic ovr);
        fsts_word = 32'h0000_0000;
        fsts_word[rfs_pkg::IDX_MSB:rfs_pkg::IDX_LSB] = idx;
        fsts_word[rfs_pkg::PEND_BIT] = pend;
        fsts_word[rfs_pkg::OVR_BIT] = ovr;
    endfunction

    // Write strobe of the access phase; reads have no side effect, so no read strobe exists.
    assign wr_acc = psel && penable && pwrite;

    // Register selects, decoded once from the word address.
    // The low two address bits are ignored, so every byte of a word selects it.
    assign sel_fsts  = hit(paddr, rfs_pkg::FSTS_OFFSET);
    assign sel_fectl = hit(paddr, rfs_pkg::FECTL_OFFSET);
    assign sel_imask = hit(paddr, rfs_pkg::IRQ_MASK_OFFSET);
    assign sel_istat = hit(paddr, rfs_pkg::IRQ_STAT_OFFSET);
    assign sel_slot  = hit(paddr, rfs_pkg::SLOT_OFFSET);

    // Byte lane 0 carries every low field; lane 3 carries the message mask.
    // A write with the lane strobe low leaves that field untouched.
    // The strobes are shared by the flag processes below.
    assign fsts_w1c  = wr_acc && pstrb[0] && sel_fsts;
    assign fectl_wr  = wr_acc && pstrb[3] && sel_fectl;
    assign imask_wr  = wr_acc && pstrb[0] && sel_imask;
    assign istat_w1c = wr_acc && pstrb[0] && sel_istat;

    // Slot marker recording and software clearing; a record that lands in a full bank overflows.
    assign slots_full = &slot_valid_q;
    generate
        for (genvar i = 0; i < rfs_pkg::SLOT_COUNT; i++)
        begin : g_slot
            assign slot_set[i] = fault_record && !slots_full &&
                                 (fault_slot == 8'(i));
            // Software frees a slot by writing one to its marker.
            assign slot_clr[i] = wr_acc && pstrb[0] && sel_slot && pwdata[i];
        end
    endgenerate

    // Slot markers stand in for the recording slots outside; set wins over clear.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            slot_valid_q <= rfs_pkg::SLOT_RESET;
        else
            slot_valid_q <= (slot_valid_q & ~slot_clr) | slot_set;
    end

    assign pend_d = |((slot_valid_q & ~slot_clr) | slot_set);
    // only a rising edge is a new condition
    assign pend_rise = pend_d && !pend_q;

    // Lowest newly set slot is the first pending one; a loop keeps it within range.
    always_comb
    begin
        first_idx = '0;
        for (int j = rfs_pkg::SLOT_COUNT - 1; j >= 0; j--)
        begin
            if (slot_set[j])
                first_idx = rfs_pkg::IDX_W'(j);
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pend_q <= 1'b0;
        else
            pend_q <= pend_d;
    end

    // index undefined when clear
    // Left unchanged while pending is clear, which software must treat as undefined.
    // Only a rise updates it, so a later fault into a lower slot cannot move the index
    // while the first one is still pending.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            index_q <= rfs_pkg::FSTS_RESET[rfs_pkg::IDX_MSB:rfs_pkg::IDX_LSB];
        else if (pend_rise)
            index_q <= first_idx;
    end

    assign ovr_set = fault_record && slots_full;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ovr_q <= 1'b0;
        else if (ovr_set)
            ovr_q <= 1'b1;
        // A clear in the same cycle as an overrun loses, so the overrun stays visible.
        else if (fsts_w1c && pwdata[rfs_pkg::OVR_BIT])
            ovr_q <= 1'b0;
    end

    // Event control mask bit; resets masked so no message leaves before software is ready.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            msg_mask_q <= rfs_pkg::FECTL_RESET[rfs_pkg::MSG_MASK_BIT];
        else if (fectl_wr)
            msg_mask_q <= pwdata[rfs_pkg::MSG_MASK_BIT];
    end

    assign msg_send = (ip_q || pend_rise) && !msg_mask_q;
    // pending rise raises the fault event
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ip_q      <= 1'b0;
            fault_msg <= 1'b0;
        end
        else
        begin
            fault_msg <= msg_send;
            if (msg_send || !pend_d)
                ip_q <= 1'b0;
            else if (pend_rise)
                ip_q <= 1'b1;
        end
    end

    // Sticky interrupt status, write one to clear; a fresh event wins over the clear.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            irq_stat_q <= rfs_pkg::IRQ_STAT_RESET;
        else
        begin
            for (int k = 0; k < 2; k++)
            begin
                if ((k == rfs_pkg::EV_PEND) ? pend_rise : ovr_set)
                    irq_stat_q[k] <= 1'b1;
                // A fresh event in the same cycle as the clear wins, so none is lost.
                else if (istat_w1c && pwdata[k])
                    irq_stat_q[k] <= 1'b0;
            end
        end
    end

    // Interrupt enable mask, one bit per event.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            irq_mask_q <= rfs_pkg::IRQ_MASK_RESET;
        else if (imask_wr)
            irq_mask_q <= pwdata[1:0];
    end

    // Level interrupt from registered status and mask.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_q & irq_mask_q);
    end

    // read word assembly
    // Reserved and unsupported bits are tied to zero here, so writes to them have no
    // effect and reads always return zero; the unsupported error bits need no state.
    // An unmapped word reads zero and raises the error flag instead.
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        rderr_d = 1'b0;
        if (sel_fsts)
            rdata_d = fsts_word(index_q, pend_q, ovr_q);
        else if (sel_fectl)
        begin
            rdata_d[rfs_pkg::MSG_MASK_BIT] = msg_mask_q;
            rdata_d[rfs_pkg::IP_BIT]       = ip_q;
        end
        else if (sel_imask)
            rdata_d[1:0] = irq_mask_q;
        else if (sel_istat)
            rdata_d[1:0] = irq_stat_q;
        else if (sel_slot)
            rdata_d[rfs_pkg::SLOT_COUNT-1:0] = slot_valid_q;
        else
            rderr_d = 1'b1;
    end

    // APB answer: the word is taken in the setup cycle and stands in the first access
    // cycle, so pready rises there with no wait state and stands for one cycle.
    // Taking the word early keeps the read path short; the price is that a fault landing
    // in the access cycle shows only on the next read.
    // prdata keeps its last word between transfers; only pready qualifies it.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pready  <= 1'b1;
            pslverr <= rderr_d;
            prdata  <= rdata_d;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // rfs_fault_status

// File: rfs_fault_status_asserts.sv
// Assertions for the remap fault status block.
`timescale 1ns/1ns
module rfs_fault_status_asserts
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fault_msg,
    input wire logic        irq
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Every mapped word, matched on the word address as the decoder does.
    wire map = {paddr[11:2], 2'b00} inside {12'h034, 12'h038, 12'h03c, 12'h040, 12'h044};
    // Bus answers come one cycle after setup and stand one cycle.
    ans_next_a: assert property (psel && !penable |=> pready)
        else $error("late answer");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("long ready");
    unmapped_err_a: assert property (pready |-> pslverr == !map)
        else $error("bad decode");
    err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("data on error");
    // Status reads keep reserved bits zero and the index in range.
    rsv_zero_a: assert property (pready && paddr == 12'h034 |->
        prdata[31:16] == 16'h0 && prdata[7:2] == 6'h0) else $error("reserved set");
    idx_range_a: assert property (pready && paddr == 12'h034 && prdata[1] |->
        prdata[15:8] < 8'h08) else $error("index range");
    msg_single_a: assert property (fault_msg |=> !fault_msg)
        else $error("repeated message");
    rst_quiet_a: assert property ($fell(sys_rst) |-> !irq && !fault_msg && !pready)
        else $error("busy after reset");
endmodule // rfs_fault_status_asserts
bind rfs_fault_status rfs_fault_status_asserts i_chk (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_msg(fault_msg), .irq(irq));

// File: rfs_fault_status_tb.sv
// Self-checking testbench for the remap fault status block.
`timescale 1ns/1ns
module rfs_fault_status_tb;
    logic        clk, sys_rst, psel, penable, pwrite, fault_record;
    logic        pready, pslverr, fault_msg, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  fault_slot;
    int          num_errors, samples_checked, cyc, msgs;
    rfs_fault_status i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_record(fault_record), .fault_slot(fault_slot),
        .fault_msg(fault_msg), .irq(irq));
    // Free clock, and message count taken on the settled half cycle.
    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    always @(negedge clk) if (fault_msg === 1'h1) msgs++;
    // Ceiling on run length so a hung handshake still ends the run.
    always @(posedge clk) if (++cyc == 20000)
    begin
        num_errors++;
        finish_test();
    end
    task finish_test();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, got);
        samples_checked++;
        if (got !== ex)
        begin
            $display("BAD %s expected %h seen %h", nm, ex, got);
            num_errors++;
        end
    endtask
    // One APB transfer: setup, then access held until pready is seen at a rising edge.
    // Only the run ceiling ends a wait that never gets its answer.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    task automatic flt(input logic [7:0] s);
        @(posedge clk);
        {fault_record, fault_slot} <= {1'h1, s};
        @(posedge clk);
        fault_record <= 1'h0;
    endtask
    task automatic t_reset();
        apb(1'h0, 12'h034, 32'h0);
        chk("status", 32'h0, rd);
        chk("no error", 32'h0, {31'h0, er});
        apb(1'h1, 12'h03c, 32'h3);
    endtask
    task automatic t_pend();
        flt(8'h05);
        apb(1'h0, 12'h034, 32'h0);
        chk("first index", 32'h502, rd);
        chk("irq", 32'h1, {31'h0, irq});
        flt(8'h02);
        apb(1'h0, 12'h034, 32'h0);
        chk("index kept", 32'h502, rd);
        chk("masked msgs", 32'h0, msgs);
        apb(1'h0, 12'h038, 32'h0);
        chk("held pending", 32'hc000_0000, rd);
        apb(1'h1, 12'h038, 32'h0);
        repeat (4) @(negedge clk);
        chk("sent msgs", 32'h1, msgs);
        apb(1'h0, 12'h038, 32'h0);
        chk("pending served", 32'h0, rd);
        apb(1'h1, 12'h044, 32'hff);
        apb(1'h0, 12'h034, 32'h0);
        chk("cleared", 32'h0, rd & 32'hffff_00ff);
    endtask
    task automatic t_ovr();
        for (int i = 0; i < 8; i++) flt(8'(i));
        flt(8'h03);
        apb(1'h0, 12'h034, 32'h0);
        chk("overflow", 32'h3, rd);
        chk("one event", 32'h2, msgs);
        apb(1'h0, 12'h040, 32'h0);
        chk("event status", 32'h3, rd);
        apb(1'h1, 12'h034, 32'hffff_ffff);
        apb(1'h0, 12'h034, 32'h0);
        chk("ovr clear", 32'h2, rd);
        apb(1'h1, 12'h03c, 32'h0);
        repeat (2) @(negedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'h1, 12'h040, 32'h3);
        apb(1'h0, 12'h040, 32'h0);
        chk("status clear", 32'h0, rd);
        apb(1'h0, 12'h100, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
    endtask
    initial
    begin
        {sys_rst, psel, penable, pwrite, fault_record} = 5'h10;
        {paddr, pwdata, fault_slot} = 52'h0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'h0;
        t_reset();
        t_pend();
        t_ovr();
        finish_test();
    end
endmodule // rfs_fault_status_tb
